// ===== hdl/tmb_timer_core.sv
// 16-bit capture/compare timer with byte-wide APB registers beside a 10-bit configuration register.
// Assumes APB master on core_clk_i; event and debug break are same-clock.
// Notes on behaviour
// RULE_01: events accepted only with event input enable
// RULE_02: enable bit gates flag onto interrupt
// RULE_03: flag set by mode condition regardless
// RULE_04: flag clears on write one or capture read
// RULE_05: top modes set flag at counter equals top
// RULE_06: frequency mode captures, restarts, flags
// RULE_07: on-event mode captures, flags, keeps counting
// RULE_08: width mode restarts, opposite edge captures
// RULE_09: combined mode flags and stops on second
// RULE_10: byte PWM compares counter with low byte
// RULE_11: run status bit, read only
// RULE_12: debug break halts unless bypass set
// RULE_13: one shared byte latch, read/write
// RULE_14: counter low and high bytes mapped
// RULE_15: bus counter write beats internal update
// RULE_16: capture modes load compare register
// RULE_17: top modes use compare register as top
// RULE_18: byte PWM bytes are independent registers
// RULE_19: three-bit field selects counter mode
// RULE_20: edge select inverts event edge actions
// RULE_21: low byte first through shared latch
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "tmb_params.svh"
module tmb_timer_core
  import tmb_pkg::*;
(
  // Clock, reset, clock enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Event routing and debug
  input wire logic event_i,
  input wire logic debug_break_i,
  // Status
  output logic irq_o,
  output logic run_o
);

  function automatic logic is_idx(input logic [5:0] a, input logic [5:0] b);
    return a == b;
  endfunction

  logic [`TMB_CFG_W-1:0] cfg_reg;
  logic ie_reg;
  logic flag_reg;
  logic halt_bypass_reg;
  tmb_byte_t latch_reg;
  tmb_byte_t snap_reg;
  logic [15:0] count_reg;
  logic [15:0] cc_reg;
  logic run_reg;
  tmb_fw_e fw_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;

  // Bus decode
  wire [5:0] idx = paddr_i[7:2];
  wire setup = psel_i & ~penable_i;
  wire done = psel_i & penable_i & pready_reg;
  wire wr = done & pwrite_i;
  wire rd = done & ~pwrite_i;
  wire tmb_byte_t wbyte = pwdata_i[7:0];
  wire mapped = is_idx(idx, `TMB_IDX_CFG) | is_idx(idx, `TMB_IDX_IRQ_EN)
    | is_idx(idx, `TMB_IDX_FLAG) | is_idx(idx, `TMB_IDX_STATUS)
    | is_idx(idx, `TMB_IDX_DBG) | is_idx(idx, `TMB_IDX_LATCH)
    | is_idx(idx, `TMB_IDX_CNT_LO) | is_idx(idx, `TMB_IDX_CNT_HI)
    | is_idx(idx, `TMB_IDX_CC_LO) | is_idx(idx, `TMB_IDX_CC_HI);
  wire wr_cfg = wr & is_idx(idx, `TMB_IDX_CFG);
  wire wr_ie = wr & is_idx(idx, `TMB_IDX_IRQ_EN);
  wire wr_flag = wr & is_idx(idx, `TMB_IDX_FLAG);
  wire wr_dbg = wr & is_idx(idx, `TMB_IDX_DBG);
  wire wr_latch = wr & is_idx(idx, `TMB_IDX_LATCH);
  wire wr_cnt_lo = wr & is_idx(idx, `TMB_IDX_CNT_LO);
  wire wr_cnt_hi = wr & is_idx(idx, `TMB_IDX_CNT_HI);
  wire wr_cc_lo = wr & is_idx(idx, `TMB_IDX_CC_LO);
  wire wr_cc_hi = wr & is_idx(idx, `TMB_IDX_CC_HI);
  wire rd_cnt_lo = rd & is_idx(idx, `TMB_IDX_CNT_LO);
  wire rd_cc_lo = rd & is_idx(idx, `TMB_IDX_CC_LO);

  // Configuration fields
  wire tmb_mode_e mode = tmb_mode_e'(
    cfg_reg[`TMB_CFG_MODE_MSB:`TMB_CFG_MODE_LSB]); // RULE_19
  wire enable = cfg_reg[`TMB_CFG_EN_BIT];
  wire edge_sel = cfg_reg[`TMB_CFG_EDGE_BIT];
  wire ev_en = cfg_reg[`TMB_CFG_EVIN_BIT];
  wire byte_pwm = mode == TMB_M_BYTE_PWM;
  wire halted = debug_break_i & ~halt_bypass_reg; // RULE_12
  wire top_mode = mode == TMB_M_PERIODIC | mode == TMB_M_TIMEOUT
    | mode == TMB_M_ONE_SHOT | byte_pwm;
  wire capture_mode = mode == TMB_M_ON_EVENT | mode == TMB_M_FREQ_MEAS
    | mode == TMB_M_WIDTH_MEAS | mode == TMB_M_FREQ_WIDTH;

  // Event qualification
  wire accept = enable & ev_en & ~halted; // RULE_01 RULE_12
  logic act;
  logic opp;

  tmb_edge_qual u_edge
  (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .event_i(event_i),
    .accept_i(accept),
    .edge_sel_i(edge_sel),
    .act_o(act),
    .opp_o(opp)
  );

  // Counting and top match
  wire tick = enable & ~halted & run_reg;
  wire [15:0] top = byte_pwm ? {8'h00, cc_reg[7:0]} : cc_reg; // RULE_10 RULE_17
  wire at_top = tick & top_mode & (count_reg == top); // RULE_05 RULE_10
  wire fw_first = mode == TMB_M_FREQ_WIDTH & act & fw_reg == TMB_FW_IDLE;
  wire fw_mid = mode == TMB_M_FREQ_WIDTH & opp & fw_reg == TMB_FW_ARMED;
  wire fw_last = mode == TMB_M_FREQ_WIDTH & act & fw_reg == TMB_FW_SECOND;

  // Capture and restart events per mode
  wire capture = (mode == TMB_M_ON_EVENT & act) // RULE_07
    | (mode == TMB_M_FREQ_MEAS & act) // RULE_06
    | (mode == TMB_M_WIDTH_MEAS & opp) // RULE_08
    | fw_mid; // RULE_16
  wire restart = (mode == TMB_M_FREQ_MEAS & act) // RULE_06
    | (mode == TMB_M_WIDTH_MEAS & act) // RULE_08
    | fw_first
    | (mode == TMB_M_ONE_SHOT & act);
  wire flag_set = at_top // RULE_03
    | (capture & ~fw_mid)
    | fw_last; // RULE_09
  wire flag_clr = (wr_flag & wbyte[`TMB_BIT0])
    | (rd_cc_lo & capture_mode); // RULE_04

  // Run state per mode
  logic run_next;
  always_comb
  begin
    run_next = run_reg;
    unique case (mode)
      TMB_M_TIMEOUT:
        run_next = act ? 1'b1 : (opp ? 1'b0 : run_reg);
      TMB_M_ONE_SHOT:
        run_next = act ? 1'b1 : (at_top ? 1'b0 : run_reg);
      TMB_M_FREQ_WIDTH:
        run_next = fw_first ? 1'b1 : (fw_last ? 1'b0 : run_reg); // RULE_09
      TMB_M_PERIODIC, TMB_M_ON_EVENT, TMB_M_FREQ_MEAS,
      TMB_M_WIDTH_MEAS, TMB_M_BYTE_PWM:
        run_next = 1'b1;
    endcase
    if (!enable)
      run_next = 1'b0;
  end

  // Combined-mode sequence
  logic [1:0] fw_code;
  tmb_fw_e fw_next;
  always_comb
  begin
    fw_code = fw_reg;
    fw_next = fw_reg;
    if (mode != TMB_M_FREQ_WIDTH || !enable)
      fw_next = TMB_FW_IDLE;
    else
      unique case (fw_code)
        2'b00: fw_next = fw_first ? TMB_FW_ARMED : TMB_FW_IDLE;
        2'b01: fw_next = fw_mid ? TMB_FW_SECOND : TMB_FW_ARMED;
        2'b10: fw_next = fw_last ? TMB_FW_IDLE : TMB_FW_SECOND;
        default: fw_next = TMB_FW_IDLE;
      endcase
  end

  // Counter: bus commit beats internal update
  wire [15:0] count_int = restart ? 16'h0000
    : (at_top ? 16'h0000
    : (tick ? count_reg + 16'h0001 : count_reg));
  wire [15:0] count_next = wr_cnt_hi ? {wbyte, latch_reg} // RULE_15 RULE_21
    : count_int; // RULE_14

  // Compare register: bus write beats capture
  wire [15:0] cc_next = wr_cc_hi
    ? (byte_pwm ? {wbyte, cc_reg[7:0]} : {wbyte, latch_reg}) // RULE_18 RULE_21
    : (wr_cc_lo & byte_pwm) ? {cc_reg[15:8], wbyte} // RULE_18
    : capture ? count_reg : cc_reg; // RULE_16

  // Shared latch: low-byte writes park here, low-byte reads fill it
  wire tmb_byte_t latch_next = wr_latch ? wbyte // RULE_13
    : (wr_cnt_lo | (wr_cc_lo & ~byte_pwm)) ? wbyte // RULE_21
    : (rd_cnt_lo | (rd_cc_lo & ~byte_pwm)) ? snap_reg // RULE_21
    : latch_reg;

  // Read mux; high bytes of 16-bit pairs come from the latch
  wire tmb_byte_t rd_byte =
    is_idx(idx, `TMB_IDX_IRQ_EN) ? {7'h00, ie_reg}
    : is_idx(idx, `TMB_IDX_FLAG) ? {7'h00, flag_reg}
    : is_idx(idx, `TMB_IDX_STATUS) ? {7'h00, run_reg} // RULE_11
    : is_idx(idx, `TMB_IDX_DBG) ? {7'h00, halt_bypass_reg}
    : is_idx(idx, `TMB_IDX_LATCH) ? latch_reg // RULE_13
    : is_idx(idx, `TMB_IDX_CNT_LO) ? count_reg[7:0] // RULE_14
    : is_idx(idx, `TMB_IDX_CNT_HI) ? latch_reg // RULE_21
    : is_idx(idx, `TMB_IDX_CC_LO) ? cc_reg[7:0]
    : is_idx(idx, `TMB_IDX_CC_HI) ? (byte_pwm ? cc_reg[15:8] : latch_reg)
    : 8'h00;
  wire [31:0] rd_word = is_idx(idx, `TMB_IDX_CFG)
    ? {22'h000000, cfg_reg} : {24'h000000, rd_byte};
  // Snapshot at setup so the latched high byte matches the low byte read
  wire tmb_byte_t snap_next = is_idx(idx, `TMB_IDX_CNT_LO)
    ? count_reg[15:8] : cc_reg[15:8];
  wire flag_next = flag_set | (flag_reg & ~flag_clr); // RULE_03 RULE_04

  // Bus answer: one fixed wait-free access phase
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      snap_reg <= `TMB_RST_BYTE;
    end
    else if (ce_i)
    begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg <= (setup & ~pwrite_i) ? rd_word : 32'h00000000;
      snap_reg <= setup ? snap_next : snap_reg;
    end
  end

  // Software-owned control; status is not writable
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= `TMB_RST_CFG;
      ie_reg <= 1'b0;
      halt_bypass_reg <= 1'b0;
      latch_reg <= `TMB_RST_BYTE;
    end
    else if (ce_i)
    begin
      cfg_reg <= wr_cfg ? pwdata_i[`TMB_CFG_W-1:0] : cfg_reg;
      ie_reg <= wr_ie ? wbyte[`TMB_BIT0] : ie_reg; // RULE_02
      halt_bypass_reg <= wr_dbg ? wbyte[`TMB_BIT0] : halt_bypass_reg;
      latch_reg <= latch_next;
    end
  end

  // Timer state
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_reg <= `TMB_RST_WORD;
      cc_reg <= `TMB_RST_WORD;
      flag_reg <= 1'b0;
      run_reg <= 1'b0;
      fw_reg <= TMB_FW_IDLE;
      irq_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      count_reg <= count_next;
      cc_reg <= cc_next;
      flag_reg <= flag_next;
      run_reg <= run_next; // RULE_11
      fw_reg <= fw_next;
      irq_reg <= flag_next & ie_reg; // RULE_02
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign run_o = run_reg;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_EVENT_GATED: assert property ( // RULE_01
    ce_i && !ev_en && capture_mode && !wr_cc_hi && !wr_cc_lo
    |=> $stable(cc_reg))
    else $error("capture taken with event input disabled");

  AST_IRQ_FOLLOWS: assert property ( // RULE_02
    ce_i && flag_reg && ie_reg && !flag_clr |=> irq_o)
    else $error("enabled flag did not raise interrupt");

  AST_FLAG_AT_TOP: assert property ( // RULE_05
    ce_i && top_mode && tick && count_reg == top
    |=> flag_reg && count_reg == 16'h0000 || $past(wr_cnt_hi))
    else $error("top match did not set flag and wrap");

  AST_W1C: assert property ( // RULE_04
    ce_i && wr_flag && wbyte[0] && !flag_set |=> !flag_reg)
    else $error("write one did not clear flag");

  AST_W0_KEEPS: assert property ( // RULE_04
    ce_i && flag_reg && wr_flag && !wbyte[0] && !rd_cc_lo |=> flag_reg)
    else $error("write zero changed flag");

  AST_FREQ_SAMPLE_IRQ_BIT: assert property ( // RULE_06
    ce_i && mode == TMB_M_FREQ_MEAS && act && !wr_cc_hi && !wr_cnt_hi
    |=> cc_reg == $past(count_reg) && count_reg == 16'h0000 && flag_reg)
    else $error("frequency capture wrong");

  AST_ON_EVENT: assert property ( // RULE_07
    ce_i && mode == TMB_M_ON_EVENT && act && !wr_cc_hi && !wr_cnt_hi
    && tick |=> cc_reg == $past(count_reg)
    && count_reg == $past(count_reg) + 16'h0001 && flag_reg)
    else $error("event capture wrong");

  AST_HALT: assert property ( // RULE_12
    ce_i && halted && !wr_cnt_hi |=> $stable(count_reg))
    else $error("counter moved during debug halt");

  AST_CNT_WRITE_WINS: assert property ( // RULE_15
    ce_i && wr_cnt_hi
    |=> count_reg == {$past(wbyte), $past(latch_reg)})
    else $error("bus counter write lost");

  AST_RUN_STOP: assert property ( // RULE_09
    ce_i && fw_last |=> !run_reg && flag_reg ##1 !ce_i || !tick)
    else $error("combined mode did not stop");

  AST_READY: assert property (
    ce_i && setup |=> pready_o)
    else $error("no ready after setup");

  COV_FREQ: cover property (ce_i && mode == TMB_M_FREQ_MEAS && act);
  COV_FW_DONE: cover property (ce_i && fw_last);
  COV_ONE_SHOT: cover property (ce_i && mode == TMB_M_ONE_SHOT && at_top);
  COV_PAIR_WR: cover property (ce_i && wr_cnt_lo ##[1:4] wr_cnt_hi);

endmodule // tmb_timer_core

// ===== hdl/tmb_params.svh
// Offsets, field positions and reset values of the capture/compare timer.
// Assumes inclusion by bare name from every file that decodes registers.
`ifndef TMB_PARAMS_SVH
`define TMB_PARAMS_SVH

// Register indices; byte address is four times the index
`define TMB_IDX_CFG 6'h00
`define TMB_IDX_IRQ_EN 6'h05
`define TMB_IDX_FLAG 6'h06
`define TMB_IDX_STATUS 6'h07
`define TMB_IDX_DBG 6'h08
`define TMB_IDX_LATCH 6'h09
`define TMB_IDX_CNT_LO 6'h0A
`define TMB_IDX_CNT_HI 6'h0B
`define TMB_IDX_CC_LO 6'h0C
`define TMB_IDX_CC_HI 6'h0D

// Configuration register fields
`define TMB_CFG_EN_BIT 0
`define TMB_CFG_MODE_LSB 4
`define TMB_CFG_MODE_MSB 6
`define TMB_CFG_EDGE_BIT 8
`define TMB_CFG_EVIN_BIT 9
`define TMB_CFG_W 10

// Single-bit registers keep their bit here
`define TMB_BIT0 0

// Reset values
`define TMB_RST_CFG 10'h000
`define TMB_RST_BYTE 8'h00
`define TMB_RST_WORD 16'h0000

`endif

// ===== hdl/tmb_pkg.sv
// Types shared by the capture/compare timer.
// Assumes nothing beyond a SystemVerilog compiler.
package tmb_pkg;

  typedef logic [7:0] tmb_byte_t;

  typedef enum logic [2:0]
  {
    TMB_M_PERIODIC = 3'b000,
    TMB_M_TIMEOUT = 3'b001,
    TMB_M_ON_EVENT = 3'b010,
    TMB_M_FREQ_MEAS = 3'b011,
    TMB_M_WIDTH_MEAS = 3'b100,
    TMB_M_FREQ_WIDTH = 3'b101,
    TMB_M_ONE_SHOT = 3'b110,
    TMB_M_BYTE_PWM = 3'b111
  } tmb_mode_e;

  typedef enum logic [1:0]
  {
    TMB_FW_IDLE = 2'b00,
    TMB_FW_ARMED = 2'b01,
    TMB_FW_SECOND = 2'b10
  } tmb_fw_e;

endpackage

// ===== hdl/tmb_edge_qual.sv
// Event edge qualifier: turns the event level into action pulses.
// Assumes the event comes from logic on the same clock.
`timescale 1ns/1ps
module tmb_edge_qual
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Event and control
  input wire logic event_i,
  input wire logic accept_i,
  input wire logic edge_sel_i,
  // Qualified pulses
  output logic act_o,
  output logic opp_o
);

  logic prev_reg;
  wire rise = event_i & ~prev_reg;
  wire fall = ~event_i & prev_reg;

  // Level history runs even while gated, so no stale edge on enable
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev_reg <= 1'b0;
    else if (ce_i)
      prev_reg <= event_i;
  end

  assign act_o = accept_i & (edge_sel_i ? fall : rise); // RULE_20
  assign opp_o = accept_i & (edge_sel_i ? rise : fall); // RULE_20

endmodule // tmb_edge_qual

// ===== verification/tmb_event_model.sv
// Event routing model: drives the event level seen by the timer.
// Assumes the bench calls its task; levels change just after rising edges.
`timescale 1ns/1ps
module tmb_event_model
(
  // Clock
  input wire logic clk_i,
  // Event level
  output logic event_o
);
  initial event_o = 1'b0;

  // Level held for whole cycles, so every edge reaches the detector
  task automatic level(input logic v, input int hold);
    @(posedge clk_i);
    event_o <= v;
    repeat (hold) @(posedge clk_i);
  endtask
endmodule // tmb_event_model

// ===== verification/tb.sv
// Testbench: APB register and event tests of the capture/compare timer.
// Assumes design files and the event model are compiled first.
`timescale 1ns/1ps
`include "tmb_params.svh"
module tb
  import tmb_pkg::*;
;
  logic clk, rst, ce, psel, penable, pwrite, ev, brk, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, irq, run;
  logic [15:0] c1, c2, c3, w;
  int failures, check_count;

  tmb_timer_core DUT (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .event_i(ev),
    .debug_break_i(brk), .irq_o(irq), .run_o(run));
  tmb_event_model EVM (.clk_i(clk), .event_o(ev));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Holds the request until pready is sampled high
  task automatic xfer(input logic wr_en, input logic [5:0] i,
                      input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      failures++;
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask

  task automatic rdc(input string nm, input logic [5:0] i,
                     input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 32'h0, r);
    chk(nm, r, e);
  endtask

  // Low byte first, so the shared latch pairs the halves
  task automatic w16(input logic [5:0] i, input logic [15:0] d);
    wr(i, {24'h0, d[7:0]});
    wr(i + 6'h01, {24'h0, d[15:8]});
  endtask

  task automatic r16(input logic [5:0] i, output logic [15:0] d);
    logic [31:0] lo, hi;
    xfer(1'b0, i, 32'h0, lo);
    xfer(1'b0, i + 6'h01, 32'h0, hi);
    d = {hi[7:0], lo[7:0]};
  endtask

  function automatic logic [31:0] cf(tmb_mode_e m, logic e, logic x);
    return {22'h0, x, e, 1'b0, m, 3'h0, 1'b1};
  endfunction

  task automatic cap_ev(input int hi_t, lo_t, output logic [15:0] c);
    EVM.level(1'b1, hi_t);
    EVM.level(1'b0, lo_t);
    rdc("flag", `TMB_IDX_FLAG, 32'h1);
    r16(`TMB_IDX_CC_LO, c);
    rdc("flag cleared by read", `TMB_IDX_FLAG, 32'h0);
  endtask

  // Gaps differ by a known amount; fixed bus overhead cancels out
  task automatic trio(input tmb_mode_e m);
    wr(`TMB_IDX_CFG, 32'h0);
    wr(`TMB_IDX_CFG, cf(m, 1'b0, 1'b1));
    cap_ev(2, 3, c1);
    cap_ev(5, 7, c2);
    cap_ev(5, 7, c3);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish;
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    brk = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 5; i < 14; i++)
      rdc("reset value", i[5:0], 32'h0);
    xfer(1'b0, 6'h3F, 32'h0, v);
    chk("unmapped error", {31'h0, last_err}, 32'h1);
    wr(`TMB_IDX_STATUS, 32'h1);
    rdc("status", `TMB_IDX_STATUS, 32'h0);
    wr(`TMB_IDX_LATCH, 32'hA5);
    rdc("latch", `TMB_IDX_LATCH, 32'hA5);
    w16(`TMB_IDX_CNT_LO, 16'h1234);
    r16(`TMB_IDX_CNT_LO, w);
    chk("count", {16'h0, w}, 32'h1234);
    rdc("latch after read", `TMB_IDX_LATCH, 32'h12);
    trio(TMB_M_ON_EVENT);
    chk("gap", {16'h0, 16'(c3 - c2 - (c2 - c1))}, 32'h7);
    trio(TMB_M_FREQ_MEAS);
    chk("period", {16'h0, 16'(c3 - c2)}, 32'h7);
    trio(TMB_M_WIDTH_MEAS);
    chk("width", {16'h0, 16'(c2 - c1)}, 32'h3);
    wr(`TMB_IDX_IRQ_EN, 32'h1);
    wr(`TMB_IDX_CFG, cf(TMB_M_ON_EVENT, 1'b1, 1'b1));
    EVM.level(1'b1, 5);
    rdc("rise ignored", `TMB_IDX_FLAG, 32'h0);
    EVM.level(1'b0, 5);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(`TMB_IDX_FLAG, 32'h0);
    rdc("flag kept", `TMB_IDX_FLAG, 32'h1);
    wr(`TMB_IDX_FLAG, 32'h1);
    rdc("flag cleared", `TMB_IDX_FLAG, 32'h0);
    wr(`TMB_IDX_CFG, cf(TMB_M_ON_EVENT, 1'b0, 1'b0));
    EVM.level(1'b1, 3);
    EVM.level(1'b0, 3);
    rdc("event disabled", `TMB_IDX_FLAG, 32'h0);
    wr(`TMB_IDX_CFG, cf(TMB_M_ON_EVENT, 1'b0, 1'b1));
    brk <= 1'b1;
    EVM.level(1'b1, 3);
    EVM.level(1'b0, 3);
    rdc("halted", `TMB_IDX_FLAG, 32'h0);
    wr(`TMB_IDX_DBG, 32'h1);
    EVM.level(1'b1, 3);
    EVM.level(1'b0, 3);
    rdc("bypass", `TMB_IDX_FLAG, 32'h1);
    brk <= 1'b0;
    wr(`TMB_IDX_IRQ_EN, 32'h0);
    wr(`TMB_IDX_CFG, 32'h0);
    wr(`TMB_IDX_FLAG, 32'h1);
    w16(`TMB_IDX_CC_LO, 16'h0005);
    w16(`TMB_IDX_CNT_LO, 16'h0000);
    wr(`TMB_IDX_CFG, cf(TMB_M_PERIODIC, 1'b0, 1'b0));
    repeat (20) @(posedge clk);
    rdc("top flag", `TMB_IDX_FLAG, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    r16(`TMB_IDX_CNT_LO, w);
    chk("wrap", {31'h0, w <= 16'h0005}, 32'h1);
    w16(`TMB_IDX_CC_LO, 16'hFFFF);
    w16(`TMB_IDX_CNT_LO, 16'hF000);
    r16(`TMB_IDX_CNT_LO, w);
    chk("write wins", {31'h0, w >= 16'hF000 && w < 16'hF020}, 32'h1);
    // Same bus overhead both ways; only the frozen span differs
    r16(`TMB_IDX_CNT_LO, c1);
    repeat (10) @(posedge clk);
    r16(`TMB_IDX_CNT_LO, c2);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    r16(`TMB_IDX_CNT_LO, c3);
    chk("enable freeze", {16'h0, 16'((c2 - c1) - (c3 - c2))}, 32'hA);
    wr(`TMB_IDX_CFG, 32'h0);
    w16(`TMB_IDX_CC_LO, 16'h0010);
    w16(`TMB_IDX_CNT_LO, 16'h0000);
    wr(`TMB_IDX_FLAG, 32'h1);
    wr(`TMB_IDX_CFG, cf(TMB_M_ONE_SHOT, 1'b0, 1'b1));
    EVM.level(1'b1, 5);
    chk("running", {31'h0, run}, 32'h1);
    EVM.level(1'b0, 30);
    rdc("stopped", `TMB_IDX_STATUS, 32'h0);
    rdc("single flag", `TMB_IDX_FLAG, 32'h1);
    r16(`TMB_IDX_CNT_LO, w);
    chk("stop at top", {16'h0, w}, 32'h0);
    wr(`TMB_IDX_CFG, cf(TMB_M_TIMEOUT, 1'b0, 1'b1));
    EVM.level(1'b1, 5);
    chk("timeout start", {31'h0, run}, 32'h1);
    EVM.level(1'b0, 5);
    chk("timeout stop", {31'h0, run}, 32'h0);
    wr(`TMB_IDX_CFG, cf(TMB_M_FREQ_WIDTH, 1'b0, 1'b1));
    wr(`TMB_IDX_FLAG, 32'h1);
    EVM.level(1'b1, 4);
    EVM.level(1'b0, 4);
    rdc("no flag yet", `TMB_IDX_FLAG, 32'h0);
    EVM.level(1'b1, 4);
    rdc("second edge stop", `TMB_IDX_STATUS, 32'h0);
    rdc("second edge flag", `TMB_IDX_FLAG, 32'h1);
    wr(`TMB_IDX_CFG, cf(TMB_M_BYTE_PWM, 1'b0, 1'b0) & 32'hFFFFFFFE);
    wr(`TMB_IDX_LATCH, 32'h5A);
    wr(`TMB_IDX_CC_LO, 32'h03);
    wr(`TMB_IDX_CC_HI, 32'h80);
    rdc("latch untouched", `TMB_IDX_LATCH, 32'h5A);
    rdc("pwm low", `TMB_IDX_CC_LO, 32'h03);
    rdc("pwm high", `TMB_IDX_CC_HI, 32'h80);
    w16(`TMB_IDX_CNT_LO, 16'h0000);
    wr(`TMB_IDX_FLAG, 32'h1);
    wr(`TMB_IDX_CFG, cf(TMB_M_BYTE_PWM, 1'b0, 1'b0));
    repeat (10) @(posedge clk);
    rdc("pwm flag", `TMB_IDX_FLAG, 32'h1);
    tally_and_finish;
  end
endmodule // tb
